// File: pwmp_top.sv
// Behaviour
// [RULE_01] mode field 0x8 or 0x9 selects symmetric dual-slope pwm
// [RULE_02] counter runs up from zero to ceiling, then back down to zero
// [RULE_03] ceiling is capture value in 0x8, compare a value in 0x9; reverse there
// [RULE_04] counter holds the ceiling for one timer tick before counting down
// [RULE_05] non-inverting: clear output on up-count match, set on down-count match
// [RULE_06] action 0x2 is non-inverted pwm, 0x3 inverted pwm
// [RULE_07] software keeps the ceiling at 0x0003 or above, up to full 16 bits
// [RULE_08] each compare match sets that channel's match flag
// [RULE_09] active compare values load from buffers when the counter is at zero
// [RULE_10] overflow flag sets on the same tick as the compare load at zero
// [RULE_11] reaching the ceiling sets compare a flag or capture flag, whichever defines it
// [RULE_12] compare above ceiling never matches; software keeps ceiling above compares
// [RULE_13] software uses capture ceiling for fixed rates, compare a for changing rates
// [RULE_14] waveform reaches the pin only when its direction bit selects output
// [RULE_15] compare zero gives steady low, compare at ceiling gives high, inverted opposite
// [RULE_16] mode 0x9 with channel a action 0x1 toggles output at each match
// [RULE_17] tick enable divides the clock by 1, 8, 64, 256 or 1024
// [RULE_18] everything runs on mclk; the tick is only a one-cycle enable
// [RULE_19] nonzero action field hands the pin to the compare output
// [RULE_20] zero action field leaves the pin as a plain port bit
// [RULE_21] compare writes go to the buffer and reach the comparator at next zero
// [RULE_22] match flag sets on the tick after the counter equals the compare value
`timescale 1ns/1ps
module pwmp_top #(
	parameter int W = pwmp_pkg::CNT_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [pwmp_pkg::ADDR_W-1:0] addr,
	input wire logic [W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [W-1:0] rdata,
	output logic [pwmp_pkg::CH_N-1:0] pin_out,
	output logic [pwmp_pkg::CH_N-1:0] pin_oe_n,
	output logic [pwmp_pkg::CH_N-1:0] compare_output,
	output logic [W-1:0] count_value
);
	localparam int N = pwmp_pkg::CH_N;

	logic [W-1:0] ctrl_q;
	logic [W-1:0] count_q;
	logic [W-1:0] capture_value_q;
	logic down_q;
	logic [pwmp_pkg::FLAG_N-1:0] flags_q;
	logic [N-1:0] port_data_q;
	logic [W-1:0] rdata_q;
	logic [N-1:0] pin_out_q;
	logic [N-1:0] pin_oe_n_q;

	logic [3:0] waveform_mode_sel;
	logic [2:0] clk_sel;
	logic [2*N-1:0] output_action_sel;
	logic [N-1:0] pin_direction_bit;
	logic timer_tick_enable;
	logic pfc;
	logic [W-1:0] top;
	logic at_top;
	logic at_bottom;
	logic top_ev;
	logic bottom_ev;
	logic eff_down;
	logic [N-1:0] match;
	logic [N-1:0] level;
	logic [N-1:0] cmp_wr;
	logic [W-1:0] cmp_active_a;
	logic [W-1:0] cmp_buf [N];
	logic [pwmp_pkg::FLAG_N-1:0] flag_set;
	logic [pwmp_pkg::FLAG_N-1:0] flag_clr;
	logic [W-1:0] rd_mux;

	// control fields
	assign waveform_mode_sel = ctrl_q[pwmp_pkg::CTRL_MODE_LSB +: 4];
	assign clk_sel = ctrl_q[pwmp_pkg::CTRL_CLK_LSB +: 3];
	assign output_action_sel = ctrl_q[pwmp_pkg::CTRL_ACT_LSB +: 2*N];
	assign pin_direction_bit = ctrl_q[pwmp_pkg::CTRL_DIR_LSB +: N];

	assign pfc = (waveform_mode_sel == pwmp_pkg::MODE_PFC_CAPTURE)
		|| (waveform_mode_sel == pwmp_pkg::MODE_PFC_CMP_A); // [RULE_01]

	// ceiling source
	assign top = (waveform_mode_sel == pwmp_pkg::MODE_PFC_CMP_A) ? cmp_active_a : capture_value_q; // [RULE_03]

	assign at_top = (count_q == top);
	assign at_bottom = (count_q == pwmp_pkg::COUNT_ZERO);
	assign top_ev = timer_tick_enable && pfc && at_top;
	assign bottom_ev = timer_tick_enable && pfc && at_bottom;
	// direction seen by a match: the ceiling counts as falling, zero as rising
	assign eff_down = at_top || (down_q && !at_bottom); // [RULE_15]

	pwmp_prescaler u_prescaler (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.clk_sel(clk_sel),
		.tick(timer_tick_enable)
	);

	pwmp_ch_if #(.W(W)) ch_if [N] ();

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_ch
			assign cmp_wr[gi] = wr && (addr == pwmp_pkg::REG_CMP_A + pwmp_pkg::ADDR_W'(gi));
			assign ch_if[gi].ce = ce;
			assign ch_if[gi].tick = timer_tick_enable;
			assign ch_if[gi].pfc = pfc;
			assign ch_if[gi].bottom_ev = bottom_ev;
			assign ch_if[gi].eff_down = eff_down;
			assign ch_if[gi].toggle_ok = (waveform_mode_sel == pwmp_pkg::MODE_PFC_CMP_A);
			assign ch_if[gi].count = count_q;
			assign ch_if[gi].top = top;
			assign ch_if[gi].action = output_action_sel[2*gi +: 2];
			assign ch_if[gi].wr = cmp_wr[gi];
			assign ch_if[gi].wdata = wdata;
			assign match[gi] = ch_if[gi].match;
			assign level[gi] = ch_if[gi].level;
			assign cmp_buf[gi] = ch_if[gi].buf_val;

			pwmp_channel #(.IS_A(gi == 0)) u_channel (
				.mclk(mclk),
				.rst(rst),
				.ch(ch_if[gi])
			);

			// pin: compare output when the action field is nonzero, else port bit
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					pin_out_q[gi] <= 1'b0;
					pin_oe_n_q[gi] <= 1'b1;
				end else if (ce) begin
					if (output_action_sel[2*gi +: 2] != pwmp_pkg::ACT_OFF) begin
						pin_out_q[gi] <= level[gi]; // [RULE_19]
					end else begin
						pin_out_q[gi] <= port_data_q[gi]; // [RULE_20]
					end
					pin_oe_n_q[gi] <= !pin_direction_bit[gi]; // [RULE_14]
				end
			end
		end
	endgenerate

	assign cmp_active_a = ch_if[0].active;

	// control and port registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= pwmp_pkg::CTRL_RESET;
		end else if (ce && wr && addr == pwmp_pkg::REG_CTRL) begin
			ctrl_q <= wdata & pwmp_pkg::CTRL_MASK;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_data_q <= '0;
		end else if (ce && wr && addr == pwmp_pkg::REG_PORT) begin
			port_data_q <= wdata[pwmp_pkg::PORT_DATA_LSB +: N];
		end
	end

	// capture register: not buffered, it defines the ceiling directly
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			capture_value_q <= pwmp_pkg::COUNT_ZERO;
		end else if (ce && wr && addr == pwmp_pkg::REG_CAPTURE) begin
			capture_value_q <= wdata;
		end
	end

	// dual-slope counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_q <= pwmp_pkg::COUNT_ZERO;
		end else if (ce) begin
			if (wr && addr == pwmp_pkg::REG_COUNT) begin
				count_q <= wdata;
			end else if (timer_tick_enable && pfc) begin
				if (!down_q) begin
					if (count_q >= top) begin
						count_q <= count_q - pwmp_pkg::COUNT_STEP; // [RULE_04]
					end else begin
						count_q <= count_q + pwmp_pkg::COUNT_STEP; // [RULE_02]
					end
				end else if (at_bottom) begin
					count_q <= count_q + pwmp_pkg::COUNT_STEP; // [RULE_02]
				end else begin
					count_q <= count_q - pwmp_pkg::COUNT_STEP;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			down_q <= 1'b0;
		end else if (ce && timer_tick_enable && pfc) begin
			if (!down_q && count_q >= top) begin
				down_q <= 1'b1; // [RULE_03]
			end else if (down_q && at_bottom) begin
				down_q <= 1'b0;
			end
		end
	end

	// flag events
	always_comb begin
		flag_set = '0;
		flag_set[pwmp_pkg::FLAG_OVF] = bottom_ev; // [RULE_10]
		flag_set[pwmp_pkg::FLAG_CMP_LSB +: N] = match; // [RULE_08] [RULE_22]
		if (top_ev && waveform_mode_sel == pwmp_pkg::MODE_PFC_CMP_A) begin
			flag_set[pwmp_pkg::FLAG_CMP_LSB] = 1'b1; // [RULE_11]
		end
		if (top_ev && waveform_mode_sel == pwmp_pkg::MODE_PFC_CAPTURE) begin
			flag_set[pwmp_pkg::FLAG_CAP] = 1'b1; // [RULE_11]
		end
	end

	assign flag_clr = (wr && addr == pwmp_pkg::REG_FLAGS) ? wdata[pwmp_pkg::FLAG_N-1:0] : '0;

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags_q <= '0;
		end else if (ce) begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// read mux
	always_comb begin
		rd_mux = '0;
		case (addr)
			pwmp_pkg::REG_CTRL: rd_mux = ctrl_q;
			pwmp_pkg::REG_COUNT: rd_mux = count_q;
			pwmp_pkg::REG_CMP_A: rd_mux = cmp_buf[0];
			pwmp_pkg::REG_CMP_B: rd_mux = cmp_buf[1];
			pwmp_pkg::REG_CAPTURE: rd_mux = capture_value_q;
			pwmp_pkg::REG_FLAGS: rd_mux[pwmp_pkg::FLAG_N-1:0] = flags_q;
			pwmp_pkg::REG_PORT: begin
				rd_mux[pwmp_pkg::PORT_DATA_LSB +: N] = port_data_q;
				rd_mux[pwmp_pkg::PORT_PIN_LSB +: N] = pin_out_q;
			end
			default: rd_mux = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (ce) begin
			rdata_q <= rd ? rd_mux : '0;
		end
	end

	// registered copies of the waveform and count for observation
	logic [N-1:0] level_q;
	logic [W-1:0] count_out_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_q <= '0;
			count_out_q <= pwmp_pkg::COUNT_ZERO;
		end else if (ce) begin
			level_q <= level;
			count_out_q <= count_q;
		end
	end

	assign rdata = rdata_q;
	assign pin_out = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;
	assign compare_output = level_q;
	assign count_value = count_out_q;
endmodule : pwmp_top

// File: pwmp_pkg.sv
package pwmp_pkg;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 3;
	localparam int CH_N = 2;
	localparam int PRE_W = 11;

	// register indices
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_COUNT = 3'h1;
	localparam logic [ADDR_W-1:0] REG_CMP_A = 3'h2;
	localparam logic [ADDR_W-1:0] REG_CMP_B = 3'h3;
	localparam logic [ADDR_W-1:0] REG_CAPTURE = 3'h4;
	localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h5;
	localparam logic [ADDR_W-1:0] REG_PORT = 3'h6;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CLK_LSB = 4;
	localparam int CTRL_ACT_LSB = 8;
	localparam int CTRL_DIR_LSB = 12;
	localparam logic [CNT_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CTRL_MASK = 16'h3F7F;

	// flag register bits
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_LSB = 1;
	localparam int FLAG_CAP = 3;
	localparam int FLAG_N = 4;

	// port register fields
	localparam int PORT_DATA_LSB = 0;
	localparam int PORT_PIN_LSB = 2;

	localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;

	localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
	localparam logic [3:0] MODE_PFC_CMP_A = 4'h9;

	typedef enum logic [1:0] {
		ACT_OFF = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_NONINV = 2'h2,
		ACT_INV = 2'h3
	} pwmp_act_e;

	// clock select codes and divider values
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_DIV1 = 3'h1;
	localparam logic [2:0] CLK_DIV8 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [2:0] CLK_DIV1024 = 3'h5;
	localparam logic [PRE_W-1:0] DIV_1 = 11'h0001;
	localparam logic [PRE_W-1:0] DIV_8 = 11'h0008;
	localparam logic [PRE_W-1:0] DIV_64 = 11'h0040;
	localparam logic [PRE_W-1:0] DIV_256 = 11'h0100;
	localparam logic [PRE_W-1:0] DIV_1024 = 11'h0400;
	localparam logic [PRE_W-1:0] PRE_ZERO = 11'h0000;
	localparam logic [PRE_W-1:0] PRE_STEP = 11'h0001;
endpackage : pwmp_pkg

// File: pwmp_ch_if.sv
`timescale 1ns/1ps
interface pwmp_ch_if #(
	parameter int W = pwmp_pkg::CNT_W
);
	logic ce;
	logic tick;
	logic pfc;
	logic bottom_ev;
	logic eff_down;
	logic toggle_ok;
	logic [W-1:0] count;
	logic [W-1:0] top;
	logic [1:0] action;
	logic wr;
	logic [W-1:0] wdata;
	logic [W-1:0] buf_val;
	logic [W-1:0] active;
	logic match;
	logic level;

	modport core (
		output ce, tick, pfc, bottom_ev, eff_down, toggle_ok, count, top, action, wr, wdata,
		input buf_val, active, match, level
	);
	modport chan (
		input ce, tick, pfc, bottom_ev, eff_down, toggle_ok, count, top, action, wr, wdata,
		output buf_val, active, match, level
	);
endinterface : pwmp_ch_if

// File: pwmp_prescaler.sv
`timescale 1ns/1ps
module pwmp_prescaler (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [2:0] clk_sel,
	output logic tick
);
	logic [pwmp_pkg::PRE_W-1:0] div;
	logic [pwmp_pkg::PRE_W-1:0] cnt_q;
	logic last;

	always_comb begin
		case (clk_sel)
			pwmp_pkg::CLK_DIV1: div = pwmp_pkg::DIV_1;
			pwmp_pkg::CLK_DIV8: div = pwmp_pkg::DIV_8;
			pwmp_pkg::CLK_DIV64: div = pwmp_pkg::DIV_64;
			pwmp_pkg::CLK_DIV256: div = pwmp_pkg::DIV_256;
			pwmp_pkg::CLK_DIV1024: div = pwmp_pkg::DIV_1024;
			default: div = pwmp_pkg::PRE_ZERO;
		endcase
	end

	assign last = (cnt_q >= div - pwmp_pkg::PRE_STEP);
	// single-cycle count enable, never a clock
	assign tick = ce && (div != pwmp_pkg::PRE_ZERO) && last; // [RULE_18]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= pwmp_pkg::PRE_ZERO;
		end else if (ce) begin
			if (div == pwmp_pkg::PRE_ZERO || last) begin
				cnt_q <= pwmp_pkg::PRE_ZERO; // [RULE_17]
			end else begin
				cnt_q <= cnt_q + pwmp_pkg::PRE_STEP;
			end
		end
	end
endmodule : pwmp_prescaler

// File: pwmp_channel.sv
`timescale 1ns/1ps
module pwmp_channel #(
	parameter bit IS_A = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	pwmp_ch_if.chan ch
);
	// a match needs the compare value inside the count range
	assign ch.match = ch.tick && ch.pfc && (ch.count == ch.active) && (ch.active <= ch.top); // [RULE_12]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ch.buf_val <= pwmp_pkg::COUNT_ZERO;
		end else if (ch.ce && ch.wr) begin
			ch.buf_val <= ch.wdata; // [RULE_21]
		end
	end

	// active value follows the buffer only at the bottom while in this mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ch.active <= pwmp_pkg::COUNT_ZERO;
		end else if (ch.ce) begin
			if (!ch.pfc) begin
				ch.active <= ch.wr ? ch.wdata : ch.buf_val;
			end else if (ch.bottom_ev) begin
				ch.active <= ch.buf_val; // [RULE_09]
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ch.level <= 1'b0;
		end else if (ch.ce && ch.match) begin
			case (ch.action)
				pwmp_pkg::ACT_NONINV: ch.level <= ch.eff_down; // [RULE_05] [RULE_15]
				pwmp_pkg::ACT_INV: ch.level <= !ch.eff_down; // [RULE_06]
				pwmp_pkg::ACT_TOGGLE: ch.level <= (IS_A && ch.toggle_ok) ? !ch.level : ch.level; // [RULE_16]
				default: ch.level <= ch.level;
			endcase
		end
	end
endmodule : pwmp_channel

// File: pwmp_load.sv
`timescale 1ns/1ps
module pwmp_load (
	input wire logic mclk,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	input wire logic clr,
	output int hi_a,
	output int hi_b
);
	logic [1:0] lvl;
	// a released pin is pulled low by the load
	assign lvl = pin_out & ~pin_oe_n;
	// high-time counters, cleared by clr
	always @(posedge mclk) begin
		hi_a <= clr ? 0 : hi_a + int'(lvl[0]);
		hi_b <= clr ? 0 : hi_b + int'(lvl[1]);
	end
endmodule : pwmp_load

// File: pwmp_top_chk.sv
`timescale 1ns/1ps
module pwmp_top_chk #(
	parameter int W = pwmp_pkg::CNT_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [pwmp_pkg::ADDR_W-1:0] addr,
	input wire logic [W-1:0] wdata,
	input wire logic wr,
	input wire logic [pwmp_pkg::CH_N-1:0] pin_out,
	input wire logic [pwmp_pkg::CH_N-1:0] pin_oe_n,
	input wire logic [pwmp_pkg::CH_N-1:0] compare_output,
	input wire logic [W-1:0] count_value
);
	logic [W-1:0] ctrl_q;
	logic [1:0] port_q;
	logic run;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// shadow of the control register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= pwmp_pkg::CTRL_RESET;
		end else if (ce && wr && addr == pwmp_pkg::REG_CTRL) begin
			ctrl_q <= wdata & pwmp_pkg::CTRL_MASK;
		end
	end
	// shadow of the port data bits
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_q <= 2'h0;
		end else if (ce && wr && addr == pwmp_pkg::REG_PORT) begin
			port_q <= wdata[1:0];
		end
	end
	assign run = ctrl_q[3:0] == pwmp_pkg::MODE_PFC_CAPTURE || ctrl_q[3:0] == pwmp_pkg::MODE_PFC_CMP_A;
	sequence quiet_s(logic c);
		(ce && !wr && c) [*3];
	endsequence
	a_count_step: assert property (
		$changed(count_value) && !$past(wr) && !$past(wr, 2) |->
		(count_value == $past(count_value) + 16'h0001 && count_value != 16'h0000) ||
		(count_value + 16'h0001 == $past(count_value) && $past(count_value) != 16'h0000))
		else $error("count stepped by other than one");
	a_mode_gate: assert property (
		quiet_s(!run) |=> $stable(count_value)) else $error("count moved outside pwm mode");
	a_stop_hold: assert property (
		quiet_s(ctrl_q[6:4] == 3'h0) |=> $stable(count_value)) else $error("count moved while stopped");
	a_top_once: assert property (
		quiet_s(run && ctrl_q[6:4] == 3'h1) |=> $changed(count_value)) else $error("count held too long");
	a_ce_freeze: assert property (
		!ce |=> $stable(count_value) && $stable(compare_output)) else $error("state moved with ce low");
	a_oe_dir: assert property (
		$stable(ctrl_q) |-> pin_oe_n == ~ctrl_q[13:12]) else $error("pin enable disagrees with direction");
	a_pin_follow_a: assert property (
		$stable(ctrl_q) && ctrl_q[9:8] != 2'h0 |-> pin_out[0] == compare_output[0])
		else $error("pin a not driven by compare");
	a_pin_follow_b: assert property (
		$stable(ctrl_q) && ctrl_q[11:10] != 2'h0 |-> pin_out[1] == compare_output[1])
		else $error("pin b not driven by compare");
	a_port_mode: assert property (
		$stable(ctrl_q) && $stable(port_q) |-> (ctrl_q[9:8] != 2'h0 || pin_out[0] == port_q[0]) &&
		(ctrl_q[11:10] != 2'h0 || pin_out[1] == port_q[1])) else $error("pin not following port bit");
endmodule : pwmp_top_chk
bind pwmp_top pwmp_top_chk #(.W(W)) pwmp_top_chk_i (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
	.wdata(wdata), .wr(wr), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_output(compare_output),
	.count_value(count_value));

// File: pwmp_top_tb_top.sv
`timescale 1ns/1ps
module pwmp_top_tb_top;
	localparam logic [15:0] CFG [6] = '{16'h3E18, 16'h3A29, 16'h3B38, 16'h3D19, 16'h3048, 16'h0A58};
	logic mclk, rst, ce, wr, rd, rd_d, clr;
	logic [2:0] addr;
	logic [15:0] wdata, rdata, count_value, exp_v, hold_v, cw;
	logic [1:0] pin_out, pin_oe_n, cmp_out;
	int hi_a, hi_b, n_fail, check_count, top, ca, cb, nd, win;
	logic [15:0] exp_q[$];
	pwmp_top pwmp_top_i (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_output(cmp_out),
		.count_value(count_value));
	pwmp_load pwmp_load_i (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .clr(clr), .hi_a(hi_a),
		.hi_b(hi_b));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge mclk);
	endtask : wreg
	task automatic rreg(input logic [2:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge mclk);
	endtask : rreg
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask : idle
	function automatic int div_of(input logic [2:0] s);
		case (s)
			3'h1: return 1;
			3'h2: return 8;
			3'h3: return 64;
			3'h4: return 256;
			default: return 1024;
		endcase
	endfunction : div_of
	// expected high cycles of a pin over the window
	function automatic int hi_exp(input logic [1:0] act, input int c, input logic dir, input logic port);
		if (!dir) return 0;
		case (act)
			2'h0: return port ? win : 0;
			2'h1: return win / 2;
			2'h2: return 4 * nd * c;
			default: return 4 * nd * (top - c);
		endcase
	endfunction : hi_exp
	task automatic end_sim;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim
	// read results are matched against the oldest note
	always @(posedge mclk) rd_d <= rd & ce;
	always @(negedge mclk) begin
		if (rd_d === 1'b1) begin
			exp_v = exp_q.pop_front();
			chk(rdata, exp_v);
		end
	end
	// run needs about 35000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		end_sim;
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		clr = 1'b0;
		addr = 3'h0;
		wdata = 16'h0000;
		void'($urandom(46115));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rreg(pwmp_pkg::REG_CTRL, pwmp_pkg::CTRL_RESET);
		rreg(pwmp_pkg::REG_FLAGS, 16'h0000);
		rreg(pwmp_pkg::REG_PORT, 16'h0000);
		wreg(3'h7, 16'hFFFF);
		rreg(3'h7, 16'h0000);
		wreg(pwmp_pkg::REG_CTRL, 16'hFFFF);
		rreg(pwmp_pkg::REG_CTRL, pwmp_pkg::CTRL_MASK);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			cw = CFG[i];
			nd = div_of(cw[6:4]);
			top = (nd > 8) ? 3 : 3 + $urandom_range(15);
			ca = $urandom_range(top);
			cb = $urandom_range(top);
			if (i == 2) begin
				ca = 0;
				cb = top;
			end
			if (cw[3:0] == pwmp_pkg::MODE_PFC_CMP_A) ca = top;
			wreg(pwmp_pkg::REG_CTRL, 16'h0000);
			wreg(pwmp_pkg::REG_CAPTURE, 16'(top));
			wreg(pwmp_pkg::REG_CMP_A, 16'(ca));
			wreg(pwmp_pkg::REG_CMP_B, 16'(cb));
			wreg(pwmp_pkg::REG_COUNT, 16'h0000);
			wreg(pwmp_pkg::REG_PORT, 16'h0001);
			wreg(pwmp_pkg::REG_CTRL, cw);
			win = 4 * nd * top;
			idle(win + 8);
			clr <= 1'b1;
			@(posedge mclk);
			clr <= 1'b0;
			repeat (win) @(posedge mclk);
			@(negedge mclk);
			chk(16'(hi_a), 16'(hi_exp(cw[9:8], ca, cw[12], 1'b1)));
			chk(16'(hi_b), 16'(hi_exp(cw[11:10], cb, cw[13], 1'b0)));
			@(posedge mclk);
			if (i == 0) begin
				@(negedge mclk);
				for (int k = 0; k < 200 && count_value !== 16'h0000; k++) @(negedge mclk);
				for (int j = 1; j <= 2 * top; j++) begin
					@(negedge mclk);
					chk(count_value, 16'(j <= top ? j : 2 * top - j));
				end
				@(posedge mclk);
				ce <= 1'b0;
				@(negedge mclk);
				hold_v = count_value;
				repeat (5) @(negedge mclk);
				chk(count_value, hold_v);
				@(posedge mclk);
				ce <= 1'b1;
			end
			$display("test config %0d done", i);
		end
		wreg(pwmp_pkg::REG_CTRL, 16'h0000);
		wreg(pwmp_pkg::REG_CAPTURE, 16'h000A);
		wreg(pwmp_pkg::REG_CMP_A, 16'h0000);
		wreg(pwmp_pkg::REG_CMP_B, 16'h0002);
		wreg(pwmp_pkg::REG_COUNT, 16'h0000);
		wreg(pwmp_pkg::REG_CTRL, 16'h0018);
		idle(1);
		for (int k = 0; k < 100 && count_value !== 16'h000A; k++) @(negedge mclk);
		@(posedge mclk);
		wreg(pwmp_pkg::REG_FLAGS, 16'h000F);
		wreg(pwmp_pkg::REG_CMP_B, 16'h000C);
		rreg(pwmp_pkg::REG_CMP_B, 16'h000C);
		idle(1);
		for (int k = 0; k < 100 && count_value !== 16'h0000; k++) @(negedge mclk);
		@(posedge mclk);
		rreg(pwmp_pkg::REG_FLAGS, 16'h0007);
		wreg(pwmp_pkg::REG_FLAGS, 16'h000F);
		idle(30);
		rreg(pwmp_pkg::REG_FLAGS, 16'h000B);
		idle(3);
		$display("test flags done");
		end_sim;
	end
endmodule : pwmp_top_tb_top
